//--- hdl/pxc_pkg.sv
// Purpose: Constants shared by the extended control and status registers.
// Assumes: Registers are 16 bits wide and reached by a 5-bit address.
// Notes:   Field positions and reset values live here only.
package pxc_pkg;
    // ==========================================================
    // Register addresses and widths
    // ==========================================================
    localparam int          PXC_DW            = 16;
    localparam int          PXC_AW            = 5;
    localparam logic [4:0]  PXC_ADDR_NP_WORD  = 5'h08;
    localparam logic [4:0]  PXC_ADDR_RSV_LO   = 5'h09;
    localparam logic [4:0]  PXC_ADDR_RSV_HI   = 5'h0F;
    localparam logic [4:0]  PXC_ADDR_EXT_CTRL = 5'h10;
    localparam logic [4:0]  PXC_ADDR_QP_STAT  = 5'h11;
    // ==========================================================
    // Extended control field positions
    // ==========================================================
    localparam int PXC_EC_OVR_WR      = 15;
    localparam int PXC_EC_ADDR_HI     = 10;
    localparam int PXC_EC_ADDR_LO     = 6;
    localparam int PXC_EC_CIPHER_TEST = 5;
    localparam int PXC_EC_NRZI_SEL    = 3;
    localparam int PXC_EC_TX_INVALID  = 2;
    localparam int PXC_EC_CIPHER_OFF  = 0;
    // Writable bits, reserved-zero bits excluded.
    localparam logic [15:0] PXC_EC_WR_MASK   = 16'h802D;
    localparam logic [15:0] PXC_EC_RESET_VAL = 16'h0008;
    // ==========================================================
    // Quick-poll status field positions
    // ==========================================================
    localparam int PXC_QP_SPEED   = 15;
    localparam int PXC_QP_DUPLEX  = 14;
    localparam int PXC_QP_PROG_HI = 13;
    localparam int PXC_QP_PROG_LO = 11;
    localparam int PXC_NP_CODE_W  = 4;
    localparam int PXC_PROG_W     = 3;
    localparam int PXC_STRAP_W    = 3;
endpackage

//--- hdl/pxc_strap_latch.sv
// Purpose: Catches the station address straps once after reset release.
// Assumes: Straps are stable around reset release.
// Notes:   Capture is clocked, never asynchronous.
`timescale 1ns/1ps
module pxc_strap_latch #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    // Strap pins and result
    input  wire logic [WIDTH-1:0] strap_in,
    output logic      [WIDTH-1:0] addr_out
);
    logic [WIDTH-1:0] addr_ff;
    logic             done_ff;
    logic [WIDTH-1:0] nxt_addr;
    logic             nxt_done;

    // A zero-width strap field has nothing to latch, so refuse it early.
    if (WIDTH < 1)
    begin : g_bad_width
        $error("pxc_strap_latch: WIDTH must be positive.");
    end

    always_comb
    begin
        nxt_addr = addr_ff;
        nxt_done = done_ff;
        if (!done_ff)
        begin
            nxt_addr = strap_in;
            nxt_done = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            addr_ff <= '0;
            done_ff <= 1'b0;
        end
        else
        begin
            addr_ff <= nxt_addr;
            done_ff <= nxt_done;
        end
    end

    assign addr_out = addr_ff;
endmodule // pxc_strap_latch

//--- hdl/pxc_regs.sv
// Purpose: Next-page partner code, extended control and quick-poll status.
// Assumes: The management frame engine issues one-cycle read/write strobes.
// Notes:   Read data is registered; it appears the cycle after the strobe.
`timescale 1ns/1ps
// How it works
// - Partner code bits 3:0 read-only, reset zero.
// - Addresses 9 to 15 read zero, no function.
// - Override enable bit self-clears after one cycle.
// - Bits 10:6 show strapped address, top zero.
// - Bit 5 selects scrambler test mode.
// - Bit 3 selects NRZI coding, resets one.
// - Bit 2 enables sending invalid code groups.
// - Bit 0 bypasses the stream scrambler.
// - Status bit 15 shows link speed.
// - Status bit 14 shows duplex mode.
// - Status bits 13:12 progress monitor, latched.
// - Status bit 11 progress LSB, reset zero.
module pxc_regs
    import pxc_pkg::*;
(
    // Clock and reset
    input  wire logic                      sys_clk_in,
    input  wire logic                      rst_in,
    // Management access
    input  wire logic [pxc_pkg::PXC_AW-1:0] mgmt_addr_in,
    input  wire logic                      mgmt_wr_in,
    input  wire logic                      mgmt_rd_in,
    input  wire logic [pxc_pkg::PXC_DW-1:0] mgmt_wdata_in,
    output logic      [pxc_pkg::PXC_DW-1:0] mgmt_rdata_out,
    // Device status inputs
    input  wire logic [pxc_pkg::PXC_NP_CODE_W-1:0] np_code_in,
    input  wire logic                      np_code_valid_in,
    input  wire logic                      speed_100_in,
    input  wire logic                      full_duplex_in,
    input  wire logic [pxc_pkg::PXC_PROG_W-1:0] an_progress_in,
    input  wire logic                      an_progress_upd_in,
    input  wire logic [pxc_pkg::PXC_STRAP_W-1:0] addr_strap_in,
    // Datapath controls
    output logic                           override_wr_out,
    output logic                           cipher_test_out,
    output logic                           nrzi_sel_out,
    output logic                           tx_invalid_out,
    output logic                           cipher_bypass_out
);
    import pxc_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    logic [PXC_NP_CODE_W-1:0] np_code_ff, nxt_np_code;
    logic [PXC_DW-1:0]        ctrl_ff, nxt_ctrl;
    logic [PXC_PROG_W-1:0]    prog_ff, nxt_prog;
    logic                     speed_ff, nxt_speed;
    logic                     duplex_ff, nxt_duplex;
    logic [PXC_DW-1:0]        rdata_ff, nxt_rdata;
    logic [PXC_STRAP_W-1:0]   strap_addr;
    logic [PXC_DW-1:0]        ctrl_view;
    logic [PXC_DW-1:0]        stat_view;

    pxc_strap_latch #(
        .WIDTH    (PXC_STRAP_W)
    ) u_strap (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .strap_in   (addr_strap_in),
        .addr_out   (strap_addr)
    );

    // ==========================================================
    // Read views
    // ==========================================================
    always_comb
    begin
        ctrl_view = ctrl_ff & PXC_EC_WR_MASK;
        ctrl_view[PXC_EC_ADDR_HI:PXC_EC_ADDR_LO] =
            {2'b00, strap_addr};
        stat_view = '0;
        stat_view[PXC_QP_SPEED]  = speed_ff;
        stat_view[PXC_QP_DUPLEX] = duplex_ff;
        stat_view[PXC_QP_PROG_HI:PXC_QP_PROG_LO] = prog_ff;
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        nxt_np_code = np_code_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_prog    = prog_ff;
        nxt_speed   = speed_100_in;
        nxt_duplex  = full_duplex_in;
        nxt_rdata   = rdata_ff;
        if (np_code_valid_in)
            nxt_np_code = np_code_in;
        // Progress field is held until the engine posts a new step.
        if (an_progress_upd_in)
            nxt_prog = an_progress_in;
        nxt_ctrl[PXC_EC_OVR_WR] = 1'b0;
        if (mgmt_wr_in && mgmt_addr_in == PXC_ADDR_EXT_CTRL)
            nxt_ctrl = mgmt_wdata_in & PXC_EC_WR_MASK;
        if (mgmt_rd_in)
        begin
            case (mgmt_addr_in)
                PXC_ADDR_NP_WORD:
                    nxt_rdata = {{(PXC_DW-PXC_NP_CODE_W){1'b0}},
                                 np_code_ff};
                PXC_ADDR_EXT_CTRL: nxt_rdata = ctrl_view;
                PXC_ADDR_QP_STAT:  nxt_rdata = stat_view;
                default:           nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            np_code_ff <= '0;
            ctrl_ff    <= PXC_EC_RESET_VAL;
            prog_ff    <= '0;
            speed_ff   <= 1'b0;
            duplex_ff  <= 1'b0;
            rdata_ff   <= '0;
        end
        else
        begin
            np_code_ff <= nxt_np_code;
            ctrl_ff    <= nxt_ctrl;
            prog_ff    <= nxt_prog;
            speed_ff   <= nxt_speed;
            duplex_ff  <= nxt_duplex;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign mgmt_rdata_out    = rdata_ff;
    assign override_wr_out   = ctrl_ff[PXC_EC_OVR_WR];
    assign cipher_test_out   = ctrl_ff[PXC_EC_CIPHER_TEST];
    assign nrzi_sel_out      = ctrl_ff[PXC_EC_NRZI_SEL];
    assign tx_invalid_out    = ctrl_ff[PXC_EC_TX_INVALID];
    assign cipher_bypass_out = ctrl_ff[PXC_EC_CIPHER_OFF];

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    chk_override_clears: assert property (
        override_wr_out |=> !override_wr_out || $past(mgmt_wr_in))
        else $error("Override enable did not clear.");
    chk_ctrl_write: assert property (
        mgmt_wr_in && mgmt_addr_in == PXC_ADDR_EXT_CTRL |=>
        cipher_test_out == $past(mgmt_wdata_in[PXC_EC_CIPHER_TEST]) &&
        nrzi_sel_out == $past(mgmt_wdata_in[PXC_EC_NRZI_SEL]))
        else $error("Control write not applied.");
    chk_ctrl_hold: assert property (
        !(mgmt_wr_in && mgmt_addr_in == PXC_ADDR_EXT_CTRL) |=>
        $stable(tx_invalid_out) && $stable(cipher_bypass_out))
        else $error("Control bits changed without a write.");
    chk_bypass_write: assert property (
        mgmt_wr_in && mgmt_addr_in == PXC_ADDR_EXT_CTRL |=>
        cipher_bypass_out == $past(mgmt_wdata_in[PXC_EC_CIPHER_OFF]) &&
        tx_invalid_out == $past(mgmt_wdata_in[PXC_EC_TX_INVALID]))
        else $error("Bypass or invalid-code bit not written.");
    chk_rsv_read: assert property (
        mgmt_rd_in && mgmt_addr_in >= PXC_ADDR_RSV_LO &&
        mgmt_addr_in <= PXC_ADDR_RSV_HI |=> mgmt_rdata_out == '0)
        else $error("Reserved address read non-zero.");
    chk_ctrl_rsv_zero: assert property (
        mgmt_rd_in && mgmt_addr_in == PXC_ADDR_EXT_CTRL |=>
        mgmt_rdata_out[14:9] == '0 && mgmt_rdata_out[4] == 1'b0 &&
        mgmt_rdata_out[1] == 1'b0)
        else $error("Reserved control bits read non-zero.");
    chk_speed_read: assert property (
        mgmt_rd_in && mgmt_addr_in == PXC_ADDR_QP_STAT |=>
        mgmt_rdata_out[PXC_QP_SPEED] == $past(speed_100_in, 2) &&
        mgmt_rdata_out[PXC_QP_DUPLEX] == $past(full_duplex_in, 2))
        else $error("Speed or duplex read wrong.");
    chk_prog_hold: assert property (
        !an_progress_upd_in ##1 mgmt_rd_in &&
        mgmt_addr_in == PXC_ADDR_QP_STAT |=>
        mgmt_rdata_out[PXC_QP_PROG_HI:PXC_QP_PROG_LO] == $past(prog_ff, 2))
        else $error("Progress field changed without update.");
    chk_np_read: assert property (
        np_code_valid_in ##1 mgmt_rd_in && mgmt_addr_in == PXC_ADDR_NP_WORD
        |=> mgmt_rdata_out == {12'h000, $past(np_code_in, 2)})
        else $error("Partner code read wrong.");

    cov_ctrl_write: cover property (
        mgmt_wr_in && mgmt_addr_in == PXC_ADDR_EXT_CTRL);
    cov_override: cover property (override_wr_out);
    cov_stat_read: cover property (
        mgmt_rd_in && mgmt_addr_in == PXC_ADDR_QP_STAT);
endmodule // pxc_regs

//--- bench/pxc_mgmt_model.sv
// Purpose: Station management controller model issuing register frames.
// Assumes: A strobe is taken at the rising edge after it is raised.
// Notes:   Idle write data is inverted so a stale word never matches.
`timescale 1ns/1ps
module pxc_mgmt_model
    import pxc_pkg::*;
(
    // Clock
    input  wire logic                       sys_clk_in,
    // Management access
    output logic      [pxc_pkg::PXC_AW-1:0] addr_out,
    output logic                            wr_out,
    output logic                            rd_out,
    output logic      [pxc_pkg::PXC_DW-1:0] wdata_out,
    input  wire logic [pxc_pkg::PXC_DW-1:0] rdata_in
);
    // ==========================================================
    // Frame tasks
    // ==========================================================
    localparam logic [15:0] RSV_BITS = 16'h7812;
    initial
    begin
        addr_out  = 5'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 16'h0000;
    end
    // Reserved control bits 14:11, 4 and 1 are sent as zero; bits 10:9 go out as given.
    task automatic wr_reg(input logic [4:0] addr, input logic [15:0] data);
        logic [15:0] val;
        val = (addr == PXC_ADDR_EXT_CTRL) ? (data & ~RSV_BITS)
                                          : data;
        @(posedge sys_clk_in);
        addr_out  <= addr;
        wdata_out <= val;
        wr_out    <= 1'b1;
        @(posedge sys_clk_in);
        wr_out    <= 1'b0;
        wdata_out <= ~val;
    endtask
    task automatic rd_reg(input logic [4:0] addr, output logic [15:0] data);
        @(posedge sys_clk_in);
        addr_out <= addr;
        rd_out   <= 1'b1;
        @(posedge sys_clk_in);
        rd_out   <= 1'b0;
        #1;
        data = rdata_in;
    endtask
endmodule // pxc_mgmt_model

//--- bench/tb_phy_extended_control_status_regs.sv
// Purpose: Self-checking bench for the extended control and status regs.
// Assumes: Straps start at 3'h5; a mid-run reset latches 3'h2 instead.
// Notes:   Register access goes through the controller model tasks.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        checked++; \
        if ((got) !== (ex)) \
        begin \
            err_total++; \
            $display("Error %s expected %h seen %h", nm, ex, got); \
        end \
    end
module tb_phy_extended_control_status_regs;
    import pxc_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic        sys_clk_in         = 1'b0;
    logic        rst_in             = 1'b1;
    logic [3:0]  np_code_in         = 4'h0;
    logic        np_code_valid_in   = 1'b0;
    logic        speed_100_in       = 1'b0;
    logic        full_duplex_in     = 1'b0;
    logic [2:0]  an_progress_in     = 3'h0;
    logic        an_progress_upd_in = 1'b0;
    logic [2:0]  addr_strap_in      = 3'h5;
    logic [4:0]  mgmt_addr;
    logic        mgmt_wr;
    logic        mgmt_rd;
    logic [15:0] mgmt_wdata;
    logic [15:0] mgmt_rdata;
    logic        ovr;
    logic        c_test;
    logic        nrzi;
    logic        tx_inv;
    logic        c_byp;
    logic [4:0]  outs;
    int          err_total          = 0;
    int          checked            = 0;
    assign outs = {ovr, c_test, nrzi, tx_inv, c_byp};
    always #2.5 sys_clk_in = ~sys_clk_in;
    // ==========================================================
    // Instances
    // ==========================================================
    pxc_regs u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .mgmt_addr_in(mgmt_addr), .mgmt_wr_in(mgmt_wr), .mgmt_rd_in(mgmt_rd),
        .mgmt_wdata_in(mgmt_wdata), .mgmt_rdata_out(mgmt_rdata),
        .np_code_in(np_code_in), .np_code_valid_in(np_code_valid_in),
        .speed_100_in(speed_100_in), .full_duplex_in(full_duplex_in),
        .an_progress_in(an_progress_in),
        .an_progress_upd_in(an_progress_upd_in),
        .addr_strap_in(addr_strap_in), .override_wr_out(ovr),
        .cipher_test_out(c_test), .nrzi_sel_out(nrzi),
        .tx_invalid_out(tx_inv), .cipher_bypass_out(c_byp));
    pxc_mgmt_model u_mgmt (.sys_clk_in(sys_clk_in), .addr_out(mgmt_addr),
        .wr_out(mgmt_wr), .rd_out(mgmt_rd), .wdata_out(mgmt_wdata),
        .rdata_in(mgmt_rdata));
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] ex,
                          input string nm);
        logic [15:0] got;
        u_mgmt.rd_reg(a, got);
        `CHK(nm, ex, got)
    endtask
    task automatic conclude();
        $display("Checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // The sequence needs about 76 cycles; allow roughly forty times that.
    initial
    begin
        #(5 * 3000);
        err_total++;
        conclude();
    end
    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        #1;
        `CHK("outs reset", 5'h04, outs)
        rd_chk(PXC_ADDR_EXT_CTRL, 16'h0148, "ctrl reset");
        rd_chk(PXC_ADDR_NP_WORD, 16'h0000, "np reset");
        rd_chk(PXC_ADDR_QP_STAT, 16'h0000, "qp reset");
        @(posedge sys_clk_in);
        np_code_in       <= 4'hA;
        np_code_valid_in <= 1'b1;
        @(posedge sys_clk_in);
        np_code_valid_in <= 1'b0;
        np_code_in       <= 4'h5;
        u_mgmt.wr_reg(PXC_ADDR_NP_WORD, 16'hFFFF);
        rd_chk(PXC_ADDR_NP_WORD, 16'h000A, "np code");
        for (int a = 9; a <= 15; a++)
        begin
            u_mgmt.wr_reg(5'(a), 16'hFFFF);
            rd_chk(5'(a), 16'h0000, "reserved");
        end
        u_mgmt.wr_reg(PXC_ADDR_EXT_CTRL, 16'h8021);
        #1;
        `CHK("outs set", 5'h19, outs)
        @(posedge sys_clk_in);
        #1;
        `CHK("outs self clear", 5'h09, outs)
        rd_chk(PXC_ADDR_EXT_CTRL, 16'h0161, "ctrl view");
        u_mgmt.wr_reg(PXC_ADDR_EXT_CTRL, 16'h07C4);
        #1;
        `CHK("outs invalid", 5'h02, outs)
        rd_chk(PXC_ADDR_EXT_CTRL, 16'h0144, "ctrl ro");
        @(posedge sys_clk_in);
        speed_100_in       <= 1'b1;
        full_duplex_in     <= 1'b1;
        an_progress_in     <= 3'h5;
        an_progress_upd_in <= 1'b1;
        @(posedge sys_clk_in);
        an_progress_upd_in <= 1'b0;
        an_progress_in     <= 3'h2;
        rd_chk(PXC_ADDR_QP_STAT, 16'hE800, "stat");
        @(posedge sys_clk_in);
        speed_100_in <= 1'b0;
        rd_chk(PXC_ADDR_QP_STAT, 16'h6800, "qp latched");
        // A code captured just before a read must show in that read.
        @(posedge sys_clk_in);
        np_code_in       <= 4'h3;
        np_code_valid_in <= 1'b1;
        rd_chk(PXC_ADDR_NP_WORD, 16'h0003, "np fresh");
        // A second reset must latch the straps afresh and nothing later.
        @(posedge sys_clk_in);
        np_code_valid_in <= 1'b0;
        rst_in           <= 1'b1;
        addr_strap_in    <= 3'h2;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        addr_strap_in <= 3'h5;
        #1;
        `CHK("outs rerst", 5'h04, outs)
        rd_chk(PXC_ADDR_EXT_CTRL, 16'h0088, "ctrl strap");
        rd_chk(PXC_ADDR_NP_WORD, 16'h0000, "np rerst");
        conclude();
    end
endmodule // tb_phy_extended_control_status_regs
